/* logic/dimp_defs.svh */
/*
 constants for the dram init and mode program block: timing counts,
 mode register select codes and field positions.
 assumes a 25 MHz system clock and an 18-bit command address bus.
*/
`ifndef DIMP_DEFS_SVH
`define DIMP_DEFS_SVH

`define DIMP_SYS_CLK_KHZ 25000
`define DIMP_INIT_WAIT_US 500
`define DIMP_INIT_WAIT_CYC ((`DIMP_INIT_WAIT_US * `DIMP_SYS_CLK_KHZ + 999) / 1000)
`define DIMP_DLL_LOCK_TCK 1024
`define DIMP_CALIB_INIT_TCK 1024
`define DIMP_ADDR_W 18
`define DIMP_MODE_REGS 7
`define DIMP_SEL_RSVD 3'h7
`define DIMP_SEL_MR3 3'h3
`define DIMP_SEL_MR4 3'h4
`define DIMP_SEL_MR5 3'h5
`define DIMP_GEAR_BIT 3
`define DIMP_PDA_BIT 4
`define DIMP_MPS_BIT 1
`define DIMP_CSL_LSB 6
`define DIMP_PAR_LSB 0
`define DIMP_CALIB_LONG_BIT 10

`endif

/* logic/dimp_pkg.sv */
/*
 types for the dram init and mode program block.
 assumes dimp_defs.svh is on the include path.
*/
package dimp_pkg;
    typedef struct packed {
        logic cke;
        logic cs_n;
        logic act_n;
        logic ras_n;
        logic cas_n;
        logic we_n;
        logic group_sel;
        logic [1:0] bank_sel;
        logic [17:0] addr;
        logic term_ctl;
    } dimp_cmd_type;

    typedef struct packed {
        logic gear_down;
        logic per_device;
        logic max_power_save;
        logic [2:0] cs_latency;
        logic [2:0] parity_latency;
    } dimp_feat_type;

    typedef enum logic [1:0] {
        ST_INTERNAL,
        ST_WAIT_CKE,
        ST_MODE,
        ST_READY
    } dimp_state_type;

    typedef enum logic [1:0] {
        CMD_OTHER,
        CMD_MODE_WR,
        CMD_CALIB_LONG
    } dimp_kind_type;
endpackage

/* logic/dimp_init_core.sv */
/*
 dram reset and initialization core with mode register storage.
 assumes command pins are synchronous to link_clk and that the
 controller keeps its side of the init sequence.
*/
`timescale 1ns/1ps
`include "dimp_defs.svh"

module dimp_init_core
    import dimp_pkg::*;
#(
    parameter int INIT_WAIT_CYC = `DIMP_INIT_WAIT_CYC,
    parameter int DLL_LOCK_CYC = `DIMP_DLL_LOCK_TCK,
    parameter int CALIB_INIT_CYC = `DIMP_CALIB_INIT_TCK
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic clk_en,
    input wire logic link_clk,
    input wire dimp_cmd_type link_cmd,
    output logic internal_init_done,
    output dimp_state_type init_state,
    output logic sys_ready,
    output logic cke_registered,
    output logic term_enable,
    output logic calib_ready,
    output logic [6:0] mode_written,
    output dimp_feat_type feat
);

    function automatic dimp_kind_type cmd_kind(input dimp_cmd_type c);
        dimp_kind_type k;
        k = CMD_OTHER;
        if (!c.cs_n && c.act_n && !c.we_n) begin
            if (!c.ras_n && !c.cas_n) begin
                k = CMD_MODE_WR;
            end else if (c.ras_n && c.cas_n && c.addr[`DIMP_CALIB_LONG_BIT]) begin
                k = CMD_CALIB_LONG;
            end
        end
        return k;
    endfunction

    // system domain: internal init timer and phase tracking
    dimp_state_type state_ff, nxt_state;
    logic [15:0] cnt_ff, nxt_cnt;
    logic done_ff, nxt_done;
    logic [1:0] up_meta_ff, up_sync_ff;
    logic srst_meta_ff, srst_ok_ff;
    logic cke_seen_ff, nxt_cke_seen;
    logic calib_ready_ff, nxt_calib_ready;

    always_comb begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        nxt_done = done_ff;
        unique case (state_ff)
            ST_INTERNAL: begin
                if (cnt_ff == 16'(INIT_WAIT_CYC - 1)) begin
                    nxt_done = 1'b1;
                    nxt_state = ST_WAIT_CKE;
                end else begin
                    nxt_cnt = cnt_ff + 16'h0001;
                end
            end
            ST_WAIT_CKE: begin
                if (up_sync_ff[0]) begin
                    nxt_state = ST_MODE;
                end
            end
            ST_MODE: begin
                if (up_sync_ff[1]) begin
                    nxt_state = ST_READY;
                end
            end
            ST_READY: begin
            end
        endcase
    end

    // reset release synchroniser for the system side
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            srst_meta_ff <= 1'b0;
            srst_ok_ff <= 1'b0;
        end else if (clk_en) begin
            srst_meta_ff <= 1'b1;
            srst_ok_ff <= srst_meta_ff;
        end
    end

    always_ff @(posedge sys_clk or negedge srst_ok_ff) begin
        if (!srst_ok_ff) begin
            state_ff <= ST_INTERNAL;
            cnt_ff <= 16'h0000;
            done_ff <= 1'b0;
            up_meta_ff <= 2'h0;
            up_sync_ff <= 2'h0;
        end else if (clk_en) begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            done_ff <= nxt_done;
            up_meta_ff <= {calib_ready_ff, cke_seen_ff};
            up_sync_ff <= up_meta_ff;
        end
    end

    assign internal_init_done = done_ff;
    assign init_state = state_ff;
    assign sys_ready = up_sync_ff[1];

    // link domain: reset release sync and init-done crossing
    logic lrst_meta_ff, lrst_ok_ff;
    logic id_meta_ff, id_sync_ff;

    always_ff @(posedge link_clk or negedge rstn) begin
        if (!rstn) begin
            lrst_meta_ff <= 1'b0;
            lrst_ok_ff <= 1'b0;
            id_meta_ff <= 1'b0;
            id_sync_ff <= 1'b0;
        end else begin
            lrst_meta_ff <= 1'b1;
            lrst_ok_ff <= lrst_meta_ff;
            id_meta_ff <= done_ff;
            id_sync_ff <= id_meta_ff;
        end
    end

    // link domain: command decode and mode register storage
    logic term_ff, nxt_term;
    logic [17:0] mem_ff [7];
    logic [17:0] nxt_mem [7];
    logic [6:0] written_ff, nxt_written;
    dimp_feat_type feat_ff, nxt_feat;
    logic calib_start;
    logic [2:0] sel;
    dimp_kind_type kind;

    always_comb begin
        kind = cmd_kind(link_cmd);
        sel = {link_cmd.group_sel, link_cmd.bank_sel};
        nxt_cke_seen = cke_seen_ff | (id_sync_ff & link_cmd.cke);
        nxt_term = cke_seen_ff & link_cmd.term_ctl;
        nxt_mem = mem_ff;
        nxt_written = written_ff;
        calib_start = cke_seen_ff && (kind == CMD_CALIB_LONG);
        if (cke_seen_ff && kind == CMD_MODE_WR && sel != `DIMP_SEL_RSVD) begin
            nxt_mem[sel] = link_cmd.addr;
            nxt_written[sel] = 1'b1;
        end
        nxt_feat.gear_down = mem_ff[`DIMP_SEL_MR3][`DIMP_GEAR_BIT];
        nxt_feat.per_device = mem_ff[`DIMP_SEL_MR3][`DIMP_PDA_BIT];
        nxt_feat.max_power_save = mem_ff[`DIMP_SEL_MR4][`DIMP_MPS_BIT];
        nxt_feat.cs_latency = mem_ff[`DIMP_SEL_MR4][`DIMP_CSL_LSB +: 3];
        nxt_feat.parity_latency = mem_ff[`DIMP_SEL_MR5][`DIMP_PAR_LSB +: 3];
    end

    always_ff @(posedge link_clk or negedge lrst_ok_ff) begin
        if (!lrst_ok_ff) begin
            cke_seen_ff <= 1'b0;
            term_ff <= 1'b0;
            written_ff <= 7'h00;
            feat_ff <= '0;
            for (int i = 0; i < `DIMP_MODE_REGS; i++) begin
                mem_ff[i] <= 18'h00000;
            end
        end else begin
            cke_seen_ff <= nxt_cke_seen;
            term_ff <= nxt_term;
            written_ff <= nxt_written;
            feat_ff <= nxt_feat;
            mem_ff <= nxt_mem;
        end
    end

    // link domain: delay lock and initial calibration timers
    logic [1:0] tmr_done;

    for (genvar g = 0; g < 2; g++) begin : g_tmr
        localparam int LIM = (g == 0) ? DLL_LOCK_CYC : CALIB_INIT_CYC;
        logic [15:0] tcnt_ff, nxt_tcnt;
        logic run_ff, nxt_run;
        logic tdone_ff, nxt_tdone;

        always_comb begin
            nxt_tcnt = tcnt_ff;
            nxt_run = run_ff;
            nxt_tdone = tdone_ff;
            if (calib_start) begin
                nxt_tcnt = 16'h0000;
                nxt_run = 1'b1;
                nxt_tdone = 1'b0;
            end else if (run_ff) begin
                if (tcnt_ff == 16'(LIM - 1)) begin
                    nxt_run = 1'b0;
                    nxt_tdone = 1'b1;
                end else begin
                    nxt_tcnt = tcnt_ff + 16'h0001;
                end
            end
        end

        always_ff @(posedge link_clk or negedge lrst_ok_ff) begin
            if (!lrst_ok_ff) begin
                tcnt_ff <= 16'h0000;
                run_ff <= 1'b0;
                tdone_ff <= 1'b0;
            end else begin
                tcnt_ff <= nxt_tcnt;
                run_ff <= nxt_run;
                tdone_ff <= nxt_tdone;
            end
        end

        assign tmr_done[g] = tdone_ff;
    end

    always_comb begin
        nxt_calib_ready = (&tmr_done) & ~calib_start;
    end

    always_ff @(posedge link_clk or negedge lrst_ok_ff) begin
        if (!lrst_ok_ff) begin
            calib_ready_ff <= 1'b0;
        end else begin
            calib_ready_ff <= nxt_calib_ready;
        end
    end

    assign cke_registered = cke_seen_ff;
    assign term_enable = term_ff;
    assign calib_ready = calib_ready_ff;
    assign mode_written = written_ff;
    assign feat = feat_ff;

    // checks
    chk_internal_wait: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        $rose(done_ff) |-> $past(cnt_ff) == 16'(INIT_WAIT_CYC - 1))
        else $error("internal init ended early");

    chk_wait_cke: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        (state_ff == ST_MODE) |-> done_ff)
        else $error("mode phase before internal init");

    chk_defaults_zero: assert property (
        @(posedge link_clk) disable iff (!rstn)
        $rose(lrst_ok_ff) |-> feat_ff == '0 && written_ff == 7'h00)
        else $error("defaults not off after reset");

    chk_term_off: assert property (
        @(posedge link_clk) disable iff (!lrst_ok_ff)
        !cke_seen_ff |=> !term_ff)
        else $error("termination on before clock enable");

    chk_cke_gate: assert property (
        @(posedge link_clk) disable iff (!lrst_ok_ff)
        $rose(cke_seen_ff) |-> $past(id_sync_ff) && $past(link_cmd.cke))
        else $error("clock enable taken during internal init");

    chk_write_store: assert property (
        @(posedge link_clk) disable iff (!lrst_ok_ff)
        (cke_seen_ff && cmd_kind(link_cmd) == CMD_MODE_WR && sel != `DIMP_SEL_RSVD)
        |=> mem_ff[$past(sel)] == $past(link_cmd.addr) && written_ff[$past(sel)])
        else $error("mode write not stored");

    chk_reserved_ignore: assert property (
        @(posedge link_clk) disable iff (!lrst_ok_ff)
        (cmd_kind(link_cmd) == CMD_MODE_WR && sel == `DIMP_SEL_RSVD
         && !calib_start) |=> written_ff == $past(written_ff))
        else $error("reserved select changed state");

    chk_gear_field: assert property (
        @(posedge link_clk) disable iff (!lrst_ok_ff)
        (cke_seen_ff && cmd_kind(link_cmd) == CMD_MODE_WR && sel == `DIMP_SEL_MR3)
        |=> ##1 feat_ff.gear_down == $past(link_cmd.addr[`DIMP_GEAR_BIT], 2))
        else $error("gear-down field wrong");

    chk_calib_wait: assert property (
        @(posedge link_clk) disable iff (!lrst_ok_ff)
        calib_start |=> !calib_ready_ff [*2])
        else $error("ready before lock and calibration");

    cov_cke_up: cover property (@(posedge link_clk) $rose(cke_seen_ff));
    cov_mr3_write: cover property (@(posedge link_clk)
        cke_seen_ff && cmd_kind(link_cmd) == CMD_MODE_WR && sel == `DIMP_SEL_MR3);
    cov_reserved: cover property (@(posedge link_clk)
        cke_seen_ff && cmd_kind(link_cmd) == CMD_MODE_WR && sel == `DIMP_SEL_RSVD);
    cov_ready: cover property (@(posedge sys_clk) state_ff == ST_READY);

endmodule

/* verif/dimp_ctl_model.sv */
/*
 controller model for the init core: drives the link command pins.
 assumes link_clk runs free and the bench calls its tasks in init order.
*/
`timescale 1ns/1ps
module dimp_ctl_model
    import dimp_pkg::*;
(
    input wire logic link_clk,
    output dimp_cmd_type link_cmd
);
    initial begin
        link_cmd = '1;
        link_cmd.cke = 1'h0;
        link_cmd.addr = 18'h0;
        link_cmd.term_ctl = 1'h0;
        // boundary-scan enable is not on this link and is held low off-chip
    end

    // deselects: spacing after writes and ahead of cke
    task automatic idle(input int n);
        repeat (n) begin
            @(posedge link_clk);
            link_cmd.cs_n <= 1'h1;
        end
    endtask

    // clock enable and static termination control
    task automatic set_pins(input logic cke, input logic term);
        @(posedge link_clk);
        link_cmd.cke <= cke;
        link_cmd.term_ctl <= term;
    endtask

    // kind 0 mode write with every address bit driven, 1 calibration (long when a[10] set),
    // 2 refresh, 3 activate; the last two must leave the device unchanged
    task automatic issue(input logic [2:0] sel, input logic [17:0] a, input logic [1:0] kind,
                         input int gap);
        @(posedge link_clk);
        link_cmd.cs_n <= 1'h0;
        link_cmd.act_n <= (kind != 2'h3);
        link_cmd.ras_n <= kind[0];
        link_cmd.cas_n <= kind[0];
        link_cmd.we_n <= (kind == 2'h2);
        {link_cmd.group_sel, link_cmd.bank_sel} <= sel;
        link_cmd.addr <= a;
        idle(gap);
    endtask
endmodule

/* verif/testbench.sv */
/*
 testbench for the init core: reset, bring-up, mode writes, calibration.
 assumes the controller model drives the link pins.
*/
`timescale 1ns/1ps
module testbench;
    import dimp_pkg::*;
    localparam int INIT_CYC = 20;
    logic sys_clk = 1'h0;
    logic link_clk = 1'h0;
    logic rstn = 1'h0;
    logic clk_en = 1'h1;
    dimp_cmd_type link_cmd;
    logic internal_init_done, sys_ready, cke_registered, term_enable, calib_ready;
    dimp_state_type init_state;
    logic [6:0] mode_written;
    logic [6:0] exp_mask;
    dimp_feat_type feat;
    int fails = 0;
    int n_compared = 0;
    int i;
    logic [2:0] order [7] = '{3'h3, 3'h6, 3'h5, 3'h4, 3'h2, 3'h1, 3'h0};
    logic [17:0] val [7] = '{18'h18, 18'h0, 18'h4, 18'h142, 18'h0, 18'h0, 18'h0};

    always #20 sys_clk = ~sys_clk;
    initial begin
        #1.3;
        forever #3 link_clk = ~link_clk;
    end

    dimp_init_core #(.INIT_WAIT_CYC(INIT_CYC), .DLL_LOCK_CYC(8), .CALIB_INIT_CYC(12)) uut (
        .sys_clk(sys_clk), .rstn(rstn), .clk_en(clk_en), .link_clk(link_clk),
        .link_cmd(link_cmd), .internal_init_done(internal_init_done),
        .init_state(init_state), .sys_ready(sys_ready), .cke_registered(cke_registered),
        .term_enable(term_enable), .calib_ready(calib_ready),
        .mode_written(mode_written), .feat(feat));

    dimp_ctl_model ctl (.link_clk(link_clk), .link_cmd(link_cmd));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic finish_test;
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic bring_up;
        for (i = 0; i < INIT_CYC + 8 && internal_init_done !== 1'h1; i++) @(posedge sys_clk);
        repeat (2) @(posedge sys_clk);
        #1;
        check(init_state, ST_WAIT_CKE, "internal init over");
        ctl.set_pins(1'h0, 1'h0);
        ctl.idle(5); // clock stable with deselects ahead of cke
        ctl.set_pins(1'h1, 1'h0);
        for (i = 0; i < 12 && cke_registered !== 1'h1; i++) @(posedge link_clk);
        #1;
        check(cke_registered, 1'h1, "cke taken");
        ctl.idle(8); // reset exit time
        for (i = 0; i < 8 && init_state !== ST_MODE; i++) @(posedge sys_clk);
        #1;
        check(init_state, ST_MODE, "mode phase");
    endtask

    initial begin
        repeat (3) @(posedge sys_clk);
        rstn <= 1'h1; // scaled reset hold
        ctl.set_pins(1'h0, 1'h1);
        ctl.idle(4);
        #1;
        check(term_enable, 1'h0, "termination before cke");
        check(feat, 9'h0, "feature defaults");
        ctl.issue(3'h3, 18'h18, 2'h0, 4);
        #1;
        check(mode_written, 7'h0, "write before cke");
        bring_up();
        exp_mask = 7'h0;
        for (int k = 0; k < 7; k++) begin
            ctl.issue(order[k], val[k], 2'h0, 8);
            #1;
            exp_mask[order[k]] = 1'h1;
            check(mode_written, exp_mask, "select decode");
        end
        check(feat, 9'h1EC, "feature fields");
        ctl.issue(3'h3, 18'h0, 2'h2, 8);
        #1;
        check(feat, 9'h1EC, "refresh ignored");
        ctl.issue(3'h7, 18'h0, 2'h0, 8);
        #1;
        check(feat, 9'h1EC, "reserved select");
        check(mode_written, 7'h7F, "reserved select mask");
        ctl.issue(3'h0, 18'h0, 2'h1, 1);
        ctl.issue(3'h0, 18'h400, 2'h3, 14);
        #1;
        check(calib_ready, 1'h0, "short calibration or activate");
        ctl.issue(3'h0, 18'h400, 2'h1, 1);
        repeat (11) @(posedge link_clk);
        #1;
        check(calib_ready, 1'h0, "calibration running");
        repeat (3) @(posedge link_clk);
        #1;
        check(calib_ready, 1'h1, "calibration done");
        for (i = 0; i < 10 && init_state !== ST_READY; i++) @(posedge sys_clk);
        #1;
        check(init_state, ST_READY, "ready state");
        check(sys_ready, 1'h1, "ready flag");
        ctl.issue(3'h3, 18'h0, 2'h0, 8); // idle device, all banks closed
        #1;
        check(feat, 9'h06C, "whole register replaced");
        ctl.set_pins(1'h1, 1'h1);
        ctl.idle(3);
        #1;
        check(term_enable, 1'h1, "termination follows pin");
        ctl.set_pins(1'h0, 1'h1);
        @(posedge sys_clk);
        rstn <= 1'h0;
        clk_en <= 1'h0;
        repeat (3) @(posedge sys_clk);
        #1;
        check({cke_registered, term_enable, calib_ready, mode_written, feat}, 19'h0,
              "reset clears");
        check(init_state, ST_INTERNAL, "reset state");
        @(posedge sys_clk);
        rstn <= 1'h1;
        repeat (INIT_CYC + 10) @(posedge sys_clk);
        #1;
        check(internal_init_done, 1'h0, "frozen without enable");
        @(posedge sys_clk);
        clk_en <= 1'h1;
        repeat (INIT_CYC - 3) @(posedge sys_clk);
        #1;
        check(internal_init_done, 1'h0, "internal init wait");
        bring_up();
        check(mode_written, 7'h0, "registers cleared by reset");
        finish_test();
    end

    initial begin
        #100000;
        fails++;
        finish_test();
    end
endmodule
